// >>> rtl/mmcs_core.sv
// Command interpreter for the motion module settings, output timer and motion reports.
`default_nettype none
module mmcs_core #(
  parameter int unsigned TICK = mmcs_pkg::TICK_CYCLES
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire mmcs_pkg::mmcs_byte_t rx,
  output logic                     rx_ready,
  output mmcs_pkg::mmcs_byte_t     tx,
  input  wire logic                tx_ready,
  input  wire logic                text_mode,
  input  wire logic                pin_is_reset,
  input  wire logic                motion_event,
  input  wire logic                motion_dir_minus,
  output mmcs_pkg::mmcs_cfg_t      cfg,
  output logic                     motion_indicator_output,
  output logic                     motion_indicator_output_n,
  output logic                     motion_pending
);
  import mmcs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    mmcs_state_t st;
    mmcs_cfg_t   cfg;
    logic [7:0]  cmd;
    logic [7:0]  acc;
    logic [1:0]  ndig;
    logic [2:0][7:0] txb;
    logic [1:0]  tx_cnt;
    logic [1:0]  tx_idx;
    logic        rep_pend;
    logic [7:0]  rep_char;
    logic [7:0]  remain;
    logic        in_min;
    logic [31:0] tick;
    logic [5:0]  sec_in_min;
    logic        latched;
  } mmcs_s_t;

  mmcs_s_t s_q;
  mmcs_s_t s_d;

  function automatic logic [7:0] yn(input logic b);
    return b ? CH_YES : CH_NO;
  endfunction

  function automatic logic [7:0] dig(input logic [7:0] v, input logic [1:0] pos);
    logic [7:0] r;
    r = 8'h00;
    case (pos)
      2'd0: r = CH_ZERO + v / 8'd100;
      2'd1: r = CH_ZERO + (v / 8'd10) % 8'd10;
      default: r = CH_ZERO + v % 8'd10;
    endcase
    return r;
  endfunction

  // Seconds value for codes below 0x80, the code with bit 8 set for minute codes, zero for off codes.
  function automatic logic [8:0] dec_time(input logic [7:0] t);
    logic [8:0] r;
    r = 9'h000;
    if (t == 8'h00 || t == TIME_OFF_HI) begin
      r = 9'h000;
    end else if (!t[7]) begin
      r = {2'b00, t[6:0]};
    end else begin
      r = {1'b1, t} ;
    end
    return r;
  endfunction

  function automatic logic needs_arg(input logic [7:0] c);
    return c == CH_M_UP || c == CH_O_UP || c == CH_P_UP || c == CH_R_UP ||
           c == CH_S_UP || c == CH_U_UP || c == CH_V_UP || c == CH_D_UP;
  endfunction

  logic [7:0] arg;
  logic       arg_done;
  logic       is_num;
  logic       dir_ok;
  logic [7:0] reply;
  logic       has_reply;
  logic       tx_busy;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d       = s_q;
    arg       = rx.data;
    arg_done  = 1'b0;
    reply     = 8'h00;
    has_reply = 1'b0;
    is_num    = 1'b0;
    tx_busy   = (s_q.tx_idx != s_q.tx_cnt);
    dir_ok    = 1'b0;
    rx_ready  = (s_q.st != MMCS_SEND) && !tx_busy;

    // Timer countdown; minute range counts sixty seconds per step.
    if (s_q.remain != 8'h00) begin
      if (s_q.tick == TICK - 1) begin
        s_d.tick = 32'd0;
        if (s_q.in_min && s_q.sec_in_min != 6'(SEC_PER_MIN - 1)) begin
          s_d.sec_in_min = s_q.sec_in_min + 6'd1;
        end else begin
          s_d.sec_in_min = 6'd0;
          s_d.remain = s_q.remain - 8'd1;
        end
      end else begin
        s_d.tick = s_q.tick + 32'd1;
      end
    end

    // Motion events, filtered by the direction modes.
    dir_ok = (s_q.cfg.single_dir == MMCS_SD_OFF) ||
             (s_q.cfg.single_dir == MMCS_SD_PLUS && !motion_dir_minus) ||
             (s_q.cfg.single_dir == MMCS_SD_MINUS && motion_dir_minus);
    if (motion_event && dir_ok) begin
      s_d.latched = 1'b1;
      if (dec_time(s_q.cfg.act_time) != 9'h000) begin
        s_d.remain     = s_q.cfg.act_time[7] ? s_q.cfg.act_time - 8'h80 : s_q.cfg.act_time;
        s_d.in_min     = s_q.cfg.act_time[7];
        s_d.tick       = 32'd0;
        s_d.sec_in_min = 6'd0;
      end
      if (s_q.cfg.unsol_en) begin
        s_d.rep_pend = 1'b1;
        s_d.rep_char = (s_q.cfg.dual_en && s_q.cfg.single_dir == MMCS_SD_OFF) ?
                       (motion_dir_minus ? CH_MINUS : CH_PLUS) : CH_M_UP;
      end
    end

    case (s_q.st)
      MMCS_IDLE: begin
        if (rx.valid && rx_ready) begin
          s_d.cmd  = rx.data;
          s_d.acc  = 8'h00;
          s_d.ndig = 2'd0;
          if (needs_arg(rx.data)) begin
            s_d.st = MMCS_ARG;
          end else begin
            has_reply = 1'b1;
            case (rx.data)
              CH_M_LO: reply = yn(s_q.cfg.unsol_en);
              CH_O_LO: begin reply = s_q.in_min ? s_q.remain + 8'h80 : s_q.remain; is_num = 1'b1; end
              CH_P_LO: begin reply = s_q.cfg.ping; is_num = 1'b1; end
              CH_R_LO: begin reply = {5'd0, s_q.cfg.range}; is_num = 1'b1; end
              CH_S_LO: begin reply = s_q.cfg.sens; is_num = 1'b1; end
              CH_U_LO: reply = yn(s_q.cfg.dual_en);
              CH_V_LO: begin
                case (s_q.cfg.single_dir)
                  MMCS_SD_PLUS:  reply = CH_PLUS;
                  MMCS_SD_MINUS: reply = CH_MINUS;
                  default:       reply = CH_DIS;
                endcase
              end
              default: has_reply = 1'b0;
            endcase
          end
        end
      end
      MMCS_ARG: begin
        if (rx.valid && rx_ready) begin
          // Ping takes one raw character; other numbers use three digits in text mode.
          if (text_mode && s_q.cmd != CH_P_UP && s_q.cmd != CH_M_UP &&
              s_q.cmd != CH_U_UP && s_q.cmd != CH_V_UP) begin
            arg = 8'((s_q.acc * 8'd10) + (rx.data - CH_ZERO));
            s_d.acc  = arg;
            s_d.ndig = s_q.ndig + 2'd1;
            arg_done = (s_q.ndig == DIGITS_TEXT - 2'd1);
          end else begin
            arg_done = 1'b1;
          end
          if (arg_done) begin
            s_d.st = MMCS_IDLE;
            case (s_q.cmd)
              CH_M_UP: if (arg == CH_YES || arg == CH_NO) s_d.cfg.unsol_en = (arg == CH_YES);
              CH_U_UP: if (arg == CH_YES || arg == CH_NO) s_d.cfg.dual_en = (arg == CH_YES);
              CH_V_UP: begin
                if (arg == CH_DIS) s_d.cfg.single_dir = MMCS_SD_OFF;
                else if (arg == CH_PLUS) s_d.cfg.single_dir = MMCS_SD_PLUS;
                else if (arg == CH_MINUS) s_d.cfg.single_dir = MMCS_SD_MINUS;
              end
              CH_P_UP: s_d.cfg.ping = arg;
              CH_R_UP: if (arg <= RANGE_MAX) s_d.cfg.range = arg[2:0];
              CH_S_UP: s_d.cfg.sens = arg;
              CH_D_UP: s_d.cfg.act_time = arg;
              CH_O_UP: begin
                // Stored regardless of pin mode; latched status untouched.
                s_d.remain     = (dec_time(arg) == 9'h000) ? 8'h00 : (arg[7] ? arg - 8'h80 : arg);
                s_d.in_min     = arg[7];
                s_d.tick       = 32'd0;
                s_d.sec_in_min = 6'd0;
              end
              default: s_d.st = MMCS_IDLE;
            endcase
          end
        end
      end
      default: s_d.st = MMCS_IDLE;
    endcase

    // Transmit queue: a reply is one byte or three digits.
    if (has_reply) begin
      if (is_num && text_mode) begin
        s_d.txb[0] = dig(reply, 2'd0);
        s_d.txb[1] = dig(reply, 2'd1);
        s_d.txb[2] = dig(reply, 2'd2);
        s_d.tx_cnt = DIGITS_TEXT;
      end else begin
        s_d.txb[0] = reply;
        s_d.tx_cnt = 2'd1;
      end
      s_d.tx_idx = 2'd0;
    end else if (tx_busy && tx_ready) begin
      s_d.tx_idx = s_q.tx_idx + 2'd1;
    end else if (!tx_busy && s_q.rep_pend && tx_ready && s_q.st == MMCS_IDLE && !rx.valid) begin
      // A motion event in the cycle the old report leaves must not be lost.
      s_d.rep_pend = motion_event && dir_ok && s_q.cfg.unsol_en;
    end
  end

  // ****************************************************************
  // Registers and outputs
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q            <= '0;
      s_q.st         <= MMCS_IDLE;
      s_q.cfg.ping   <= PING_RST;
      s_q.cfg.sens   <= SENS_RST;
      s_q.cfg.act_time <= ACT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  logic rep_out;
  assign rep_out = (s_q.tx_idx == s_q.tx_cnt) && s_q.rep_pend && s_q.st == MMCS_IDLE && !rx.valid;

  always_comb begin
    tx.valid = (s_q.tx_idx != s_q.tx_cnt) || rep_out;
    tx.data  = (s_q.tx_idx != s_q.tx_cnt) ? s_q.txb[s_q.tx_idx] : s_q.rep_char;
  end

  assign cfg                       = s_q.cfg;
  assign motion_indicator_output   = (s_q.remain != 8'h00) && !pin_is_reset;
  assign motion_indicator_output_n = !motion_indicator_output;
  assign motion_pending            = s_q.latched;
endmodule : mmcs_core
`default_nettype wire

// >>> pkg/mmcs_pkg.sv
// Package with the character codes, settings layout and timing constants of the motion command block.
`default_nettype none
package mmcs_pkg;
  localparam logic [7:0] CH_M_LO  = 8'h6D;
  localparam logic [7:0] CH_M_UP  = 8'h4D;
  localparam logic [7:0] CH_O_LO  = 8'h6F;
  localparam logic [7:0] CH_O_UP  = 8'h4F;
  localparam logic [7:0] CH_P_LO  = 8'h70;
  localparam logic [7:0] CH_P_UP  = 8'h50;
  localparam logic [7:0] CH_R_LO  = 8'h72;
  localparam logic [7:0] CH_R_UP  = 8'h52;
  localparam logic [7:0] CH_S_LO  = 8'h73;
  localparam logic [7:0] CH_S_UP  = 8'h53;
  localparam logic [7:0] CH_U_LO  = 8'h75;
  localparam logic [7:0] CH_U_UP  = 8'h55;
  localparam logic [7:0] CH_V_LO  = 8'h76;
  localparam logic [7:0] CH_V_UP  = 8'h56;
  localparam logic [7:0] CH_D_UP  = 8'h44;
  localparam logic [7:0] CH_YES   = 8'h59;
  localparam logic [7:0] CH_NO    = 8'h4E;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DIS   = 8'h41;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] PING_RST = 8'h01;
  localparam logic [7:0] RANGE_MAX = 8'h07;
  localparam logic [7:0] TIME_OFF_HI = 8'h80;
  localparam logic [7:0] SENS_RST  = 8'h00;
  localparam logic [7:0] ACT_RST   = 8'h00;
  localparam logic [1:0] DIGITS_TEXT = 2'd3;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned SEC_PER_MIN  = 60;
  localparam int unsigned TICK_CYCLES  = CLK_HZ;

  typedef enum logic [2:0] {
    MMCS_IDLE = 3'b000,
    MMCS_ARG  = 3'b001,
    MMCS_SEND = 3'b011
  } mmcs_state_t;

  typedef enum logic [1:0] {
    MMCS_SD_OFF   = 2'd0,
    MMCS_SD_PLUS  = 2'd1,
    MMCS_SD_MINUS = 2'd2
  } mmcs_sdir_t;

  typedef struct packed {
    logic       unsol_en;
    logic       dual_en;
    mmcs_sdir_t single_dir;
    logic [2:0] range;
    logic [7:0] sens;
    logic [7:0] ping;
    logic [7:0] act_time;
  } mmcs_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mmcs_byte_t;
endpackage : mmcs_pkg
`default_nettype wire

// >>> verif/mmcs_monitor.sv
// Checker of the motion command block port behaviour.
`default_nettype none
module mmcs_monitor (
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire mmcs_pkg::mmcs_byte_t rx,
  input wire logic                 rx_ready,
  input wire mmcs_pkg::mmcs_byte_t tx,
  input wire logic                 text_mode,
  input wire logic                 pin_is_reset,
  input wire logic                 motion_event,
  input wire logic                 motion_dir_minus,
  input wire mmcs_pkg::mmcs_cfg_t  cfg,
  input wire logic                 motion_indicator_output,
  input wire logic                 motion_pending
);
  import mmcs_pkg::*;
  // ****************
  // Argument tracking
  // ****************
  // Argument bytes are tracked here so a data byte is never mistaken for a command.
  logic       take;
  logic [1:0] left_q;
  logic [7:0] cmd_q;
  assign take = rx.valid && rx_ready;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      left_q <= 2'd0;
      cmd_q  <= 8'h00;
    end else if (take && left_q != 2'd0) begin
      left_q <= left_q - 2'd1;
    end else if (take && rx.data inside {CH_O_UP, CH_R_UP, CH_S_UP, CH_D_UP}) begin
      left_q <= text_mode ? 2'd3 : 2'd1;
      cmd_q  <= rx.data;
    end else if (take && rx.data inside {CH_M_UP, CH_P_UP, CH_U_UP, CH_V_UP}) begin
      left_q <= 2'd1;
      cmd_q  <= rx.data;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_cmd(logic [7:0] c);
    take && left_q == 2'd0 && rx.data == c;
  endsequence
  sequence s_arg(logic [7:0] c);
    take && left_q == 2'd1 && cmd_q == c && !text_mode;
  endsequence
  sequence s_evt;
    motion_event && cfg.unsol_en && !rx.valid && left_q == 2'd0;
  endsequence
  // ****************
  // Properties
  // ****************
  property p_unsol;
    motion_event && cfg.unsol_en && !cfg.dual_en && cfg.single_dir == MMCS_SD_OFF && !rx.valid && left_q == 2'd0
      |-> ##[1:4] (tx.valid && tx.data == CH_M_UP);
  endproperty
  a_unsol: assert property (p_unsol) else $error("motion report missing");
  property p_rpt_dual;
    s_evt ##0 (motion_dir_minus && cfg.dual_en && cfg.single_dir == MMCS_SD_OFF)
      |-> ##[1:4] (tx.valid && tx.data == CH_MINUS);
  endproperty
  a_rpt_dual: assert property (p_rpt_dual) else $error("dual mode report missing");
  property p_rpt_single;
    s_evt ##0 (!motion_dir_minus && cfg.single_dir == MMCS_SD_PLUS)
      |-> ##[1:4] (tx.valid && tx.data == CH_M_UP);
  endproperty
  a_rpt_single: assert property (p_rpt_single) else $error("single mode report wrong");
  property p_rd_unsol;
    s_cmd(CH_M_LO) |=> tx.valid && tx.data == (cfg.unsol_en ? CH_YES : CH_NO);
  endproperty
  a_rd_unsol: assert property (p_rd_unsol) else $error("bad unsolicited mode reply");
  property p_wr_unsol;
    s_arg(CH_M_UP) ##0 (rx.data == CH_YES) |=> cfg.unsol_en;
  endproperty
  a_wr_unsol: assert property (p_wr_unsol) else $error("unsolicited mode not set");
  property p_ovr_on;
    s_arg(CH_O_UP) ##0 (rx.data inside {[8'h01:8'h7F]} && !pin_is_reset) |-> ##[1:2] motion_indicator_output;
  endproperty
  a_ovr_on: assert property (p_ovr_on) else $error("override did not drive output");
  property p_pin_rst;
    pin_is_reset && $past(pin_is_reset) |-> !motion_indicator_output;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("output driven in reset pin mode");
  property p_pend_kept;
    s_arg(CH_O_UP) ##0 !motion_event |=> $stable(motion_pending);
  endproperty
  a_pend_kept: assert property (p_pend_kept) else $error("override changed motion status");
  property p_after_rst;
    $fell(reset) |-> cfg.ping == PING_RST && cfg.range == 3'd0 && !tx.valid;
  endproperty
  a_after_rst: assert property (p_after_rst) else $error("bad settings after reset");
  property p_rd_range;
    s_cmd(CH_R_LO) ##0 !text_mode |=> tx.valid && tx.data == {5'd0, cfg.range};
  endproperty
  a_rd_range: assert property (p_rd_range) else $error("bad range reply");
  property p_rd_dual;
    s_cmd(CH_U_LO) |=> tx.valid && tx.data == (cfg.dual_en ? CH_YES : CH_NO);
  endproperty
  a_rd_dual: assert property (p_rd_dual) else $error("bad dual mode reply");
  property p_range_bad;
    s_arg(CH_R_UP) ##0 (rx.data > RANGE_MAX) |=> $stable(cfg.range);
  endproperty
  a_range_bad: assert property (p_range_bad) else $error("range took a bad value");
endmodule // mmcs_monitor
bind mmcs_core mmcs_monitor u_mon (.core_clk(core_clk), .reset(reset), .rx(rx), .rx_ready(rx_ready), .tx(tx),
  .text_mode(text_mode), .pin_is_reset(pin_is_reset), .motion_event(motion_event),
  .motion_dir_minus(motion_dir_minus), .cfg(cfg),
  .motion_indicator_output(motion_indicator_output), .motion_pending(motion_pending));
`default_nettype wire

// >>> verif/mmcs_host.sv
// Host side model that takes reply bytes, stalling on request.
`default_nettype none
module mmcs_host (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire mmcs_pkg::mmcs_byte_t tx,
  input  wire logic                 stall,
  output logic                      tx_ready
);
  import mmcs_pkg::*;
  logic [7:0] got[$];
  initial tx_ready = 1'b0;
  always @(negedge core_clk) tx_ready <= !stall && !reset;
  // Each byte is one whole value or one digit of a three digit value.
  always @(posedge core_clk) if (tx.valid && tx_ready) got.push_back(tx.data);
endmodule // mmcs_host
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking testbench of the motion command block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mmcs_pkg::*;
  logic       core_clk, reset, rx_ready, tx_ready, text_mode, pin_is_reset;
  logic       motion_event, motion_dir_minus, stall, mio, mio_n, pend, p0;
  mmcs_byte_t rx, tx;
  mmcs_cfg_t  cfg;
  int         fails, tests_run;
  mmcs_core #(.TICK(10)) dut (.core_clk(core_clk), .reset(reset), .rx(rx), .rx_ready(rx_ready), .tx(tx),
    .tx_ready(tx_ready), .text_mode(text_mode), .pin_is_reset(pin_is_reset), .motion_event(motion_event),
    .motion_dir_minus(motion_dir_minus), .cfg(cfg), .motion_indicator_output(mio),
    .motion_indicator_output_n(mio_n), .motion_pending(pend));
  mmcs_host host (.core_clk(core_clk), .reset(reset), .tx(tx), .stall(stall), .tx_ready(tx_ready));
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge core_clk);
    rx = '{1'b1, b};
    #1;
    while (!rx_ready && n < 200) begin
      @(negedge core_clk);
      #1;
      n++;
    end
    if (n == 200) check("rx ready", {7'd0, rx_ready}, 8'h01);
    @(negedge core_clk);
    rx = '{1'b0, 8'h00};
  endtask
  task automatic get(input string nm, input logic [7:0] exp);
    int n;
    n = 0;
    while (host.got.size() == 0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    check(nm, host.got.size() ? host.got.pop_front() : 8'hXX, exp);
  endtask
  task automatic rd(input string nm, input logic [7:0] c, input logic [7:0] e);
    send(c);
    get(nm, e);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    send(c);
    send(v);
  endtask
  task automatic motion(input logic minus);
    @(negedge core_clk);
    motion_event = 1'b1;
    motion_dir_minus = minus;
    @(negedge core_clk);
    motion_event = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_report();
    rd("ping", CH_P_LO, PING_RST);
    rd("single", CH_V_LO, CH_DIS);
    wr(CH_M_UP, CH_YES);
    rd("unsol", CH_M_LO, CH_YES);
    check("no motion", {7'd0, pend}, 8'h00);
    motion(1'b0);
    get("report", CH_M_UP);
    check("latched", {7'd0, pend}, 8'h01);
    wr(CH_U_UP, CH_YES);
    rd("dual", CH_U_LO, CH_YES);
    motion(1'b1);
    get("dual dir", CH_MINUS);
    wr(CH_V_UP, CH_PLUS);
    rd("single", CH_V_LO, CH_PLUS);
    motion(1'b1);
    check("wrong dir", 8'(host.got.size()), 8'h00);
    motion(1'b0);
    get("single rpt", CH_M_UP);
    wr(CH_U_UP, CH_NO);
    wr(CH_V_UP, CH_MINUS);
    wr(CH_V_UP, 8'h51);
    rd("single", CH_V_LO, CH_MINUS);
    wr(CH_V_UP, CH_DIS);
    wr(CH_M_UP, CH_NO);
    motion(1'b0);
    check("quiet", 8'(host.got.size()), 8'h00);
  endtask
  task automatic t_override();
    p0 = pend;
    wr(CH_O_UP, 8'h82);
    check("out on", {7'd0, mio}, 8'h01);
    check("out inv", {7'd0, mio_n}, 8'h00);
    check("pending", {7'd0, pend}, {7'd0, p0});
    rd("remain", CH_O_LO, 8'h82);
    wr(CH_D_UP, 8'h81);
    motion(1'b0);
    rd("restart", CH_O_LO, 8'h81);
    wr(CH_O_UP, TIME_OFF_HI);
    repeat (3) @(negedge core_clk);
    check("off 128", {7'd0, mio}, 8'h00);
    wr(CH_O_UP, 8'h01);
    check("short on", {7'd0, mio}, 8'h01);
    repeat (40) @(negedge core_clk);
    check("expired", {7'd0, mio}, 8'h00);
    pin_is_reset = 1'b1;
    wr(CH_O_UP, 8'h83);
    check("rst pin", {7'd0, mio}, 8'h00);
    rd("rst remain", CH_O_LO, 8'h83);
    pin_is_reset = 1'b0;
  endtask
  task automatic t_values();
    wr(CH_R_UP, 8'h09);
    rd("range bad", CH_R_LO, 8'h00);
    wr(CH_R_UP, 8'h07);
    rd("range", CH_R_LO, 8'h07);
    stall = 1'b1;
    send(CH_S_LO);
    repeat (5) @(negedge core_clk);
    check("busy", {7'd0, rx_ready}, 8'h00);
    stall = 1'b0;
    get("sens", SENS_RST);
    wr(CH_S_UP, 8'hFF);
    rd("sens", CH_S_LO, 8'hFF);
    wr(CH_P_UP, 8'h31);
    text_mode = 1'b1;
    rd("ping d0", CH_P_LO, 8'h30);
    get("ping d1", 8'h34);
    get("ping d2", 8'h39);
    send(CH_S_UP);
    send(8'h31);
    send(8'h32);
    send(8'h38);
    text_mode = 1'b0;
    rd("sens text", CH_S_LO, 8'h80);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    final_report();
  end
  initial begin
    {reset, text_mode, pin_is_reset, motion_event, motion_dir_minus, stall} = 6'b100000;
    rx = '{1'b0, 8'h00};
    fails = 0;
    tests_run = 0;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    t_report();
    t_override();
    t_values();
    final_report();
  end
endmodule // testbench
`default_nettype wire
